// >>> rtl/lcd_mem_bias_ctrl.sv
// LCD memory clear, display select and bias control with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "lcd_mem_bias_cfg.svh"
module lcd_mem_bias_ctrl
  import lcd_mem_bias_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic altPhase,
  input wire logic [2:0] srcTicks,
  input wire logic [4:0] segWrIdx,
  input wire logic [7:0] segWrData,
  input wire logic segWrEn,
  input wire logic blkWrEn,
  output logic [7:0] shownSeg0,
  output logic displaySelect,
  output logic pumpOn,
  output logic [3:0] refCodeOut,
  output logic [11:0] refMillivolt,
  output logic [1:0] effBlinkMode,
  output logic pumpClk
);
  typedef struct packed {
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] biasCtrl;
    logic [15:0] auxCtrl;
    logic dispSel;
    logic [1:0] prevMode;
    clr_state_e segClr;
    clr_state_e blkClr;
    logic [4:0] segIdx;
    logic [4:0] blkIdx;
    logic pumpOn;
    logic [3:0] refCode;
    logic [11:0] refMv;
    logic [1:0] effMode;
    logic [7:0] shown0;
    logic pumpClk;
  } state_s;
  state_s s_r;
  state_s s_nxt;
  logic [7:0] segMem [0:`MEM_WORDS-1];
  logic [7:0] blkMem [0:`MEM_WORDS-1];
  logic pumpTick;
  pump_cfg_s pumpCfg;
  function automatic logic [15:0] mergeHalf(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = d[7:0];
    if (be[1]) r[15:8] = d[15:8];
    return r;
  endfunction
  function automatic logic muxFivePlus(input logic [2:0] mux);
    return mux >= `MUX_FIVE;
  endfunction
  logic [1:0] mode;
  logic [2:0] muxSet;
  logic highMux;
  logic wrFire;
  logic [15:0] memRead;
  logic [15:0] memWrite;
  logic wrOk;
  always_comb begin
    mode = s_r.auxCtrl[`AUX_BLKMOD_LSB +: 2];
    muxSet = s_r.auxCtrl[`AUX_MUX_LSB +: 3];
    highMux = muxFivePlus(muxSet);
    wrFire = s_r.awHeld && s_r.wHeld && !s_r.bValid;
    memRead = 16'h0000;
    memRead[`MEM_DISP_BIT] = s_r.dispSel;
    memRead[`MEM_CLRM_BIT] = (s_r.segClr == CLR_RUN);
    memRead[`MEM_CLRBM_BIT] = (s_r.blkClr == CLR_RUN);
    memWrite = mergeHalf(`MEM_CTRL_RST, s_r.wData, s_r.wStrb);
    s_nxt = s_r;
    wrOk = 1'b0;
    if (s_axi_awvalid && !s_r.awHeld) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.wHeld) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
    end
    if (s_r.bValid && s_axi_bready) begin
      s_nxt.bValid = 1'b0;
    end
    // Segment clear walks one word per cycle and holds its bit until done.
    if (s_r.segClr == CLR_RUN) begin
      s_nxt.segIdx = s_r.segIdx + 5'h01;
      if (s_r.segIdx == 5'(`MEM_WORDS - 1)) begin
        s_nxt.segClr = CLR_IDLE;
        s_nxt.segIdx = 5'h00;
      end
    end
    if (s_r.blkClr == CLR_RUN) begin
      s_nxt.blkIdx = s_r.blkIdx + 5'h01;
      if (s_r.blkIdx == 5'(`MEM_WORDS - 1)) begin
        s_nxt.blkClr = CLR_IDLE;
        s_nxt.blkIdx = 5'h00;
      end
    end
    if (wrFire) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld = 1'b0;
      s_nxt.bValid = 1'b1;
      wrOk = 1'b1;
      unique case (s_r.awAddr)
        `OFS_MEM_CTRL: begin
          if (memWrite[`MEM_CLRM_BIT] && s_r.segClr == CLR_IDLE) begin
            s_nxt.segClr = CLR_RUN;
          end
          if (memWrite[`MEM_CLRBM_BIT] && !highMux && s_r.blkClr == CLR_IDLE) begin
            s_nxt.blkClr = CLR_RUN;
          end
          if (s_r.wStrb[0] && mode == BLINK_OFF) begin
            s_nxt.dispSel = memWrite[`MEM_DISP_BIT];
          end
        end
        `OFS_BIAS_CTRL: s_nxt.biasCtrl = mergeHalf(s_r.biasCtrl, s_r.wData, s_r.wStrb)
                                         & 16'hFFC0;
        `OFS_AUX_CTRL: s_nxt.auxCtrl = mergeHalf(s_r.auxCtrl, s_r.wData, s_r.wStrb)
                                       & 16'h0FFF;
        `OFS_STATUS: wrOk = 1'b1;
        default: wrOk = 1'b0;
      endcase
      s_nxt.bResp = wrOk ? 2'b00 : 2'b10;
    end
    // Display select: forcing and mirroring override software.
    if (highMux || mode == BLINK_SEL || mode == BLINK_ALL) begin
      s_nxt.dispSel = 1'b0;
    end else if (mode == BLINK_ALT) begin
      s_nxt.dispSel = altPhase;
    end else if (s_r.prevMode == BLINK_ALT) begin
      s_nxt.dispSel = 1'b0;
    end
    s_nxt.prevMode = mode;
    if (muxSet > `MUX_FIVE && (mode == BLINK_SEL || mode == BLINK_ALT)) begin
      s_nxt.effMode = BLINK_OFF;
    end else begin
      s_nxt.effMode = mode;
    end
    s_nxt.arReady = 1'b0;
    if (s_axi_arvalid && !s_r.arReady && !s_r.rValid) begin
      s_nxt.arReady = 1'b1;
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = 2'b00;
      unique case (s_axi_araddr)
        `OFS_MEM_CTRL: s_nxt.rData = {16'h0000, memRead};
        `OFS_BIAS_CTRL: s_nxt.rData = {16'h0000, s_r.biasCtrl};
        `OFS_AUX_CTRL: s_nxt.rData = {16'h0000, s_r.auxCtrl};
        `OFS_STATUS: s_nxt.rData = {16'h0000, 4'h0, s_r.refMv};
        default: begin
          s_nxt.rData = 32'h00000000;
          s_nxt.rResp = 2'b10;
        end
      endcase
    end
    if (s_r.rValid && s_axi_rready) begin
      s_nxt.rValid = 1'b0;
    end
    s_nxt.pumpOn = s_r.biasCtrl[`BIAS_PEN_BIT]
                   && !s_r.auxCtrl[`AUX_EXT_BIT]
                   && (s_r.biasCtrl[`BIAS_VREF_LSB +: 4] != 4'h0
                       || s_r.auxCtrl[`AUX_REFLVL_LSB +: 4] != 4'h0);
    if (s_r.biasCtrl[`BIAS_PEN_BIT] && s_r.biasCtrl[`BIAS_REFEN_BIT]) begin
      s_nxt.refCode = s_r.biasCtrl[`BIAS_VREF_LSB +: 4];
      s_nxt.refMv = `VREF_BASE_MV
                    + 12'(`VREF_STEP_MV * {8'h00, s_r.biasCtrl[`BIAS_VREF_LSB +: 4]});
    end else begin
      s_nxt.refCode = 4'h0;
      s_nxt.refMv = 12'h000;
    end
    s_nxt.shown0 = s_r.dispSel ? blkMem[0] : segMem[0];
    // The pump clock drops with its enable, so no edge follows a switch-off.
    if (!s_nxt.pumpOn) begin
      s_nxt.pumpClk = 1'b0;
    end else if (pumpTick) begin
      s_nxt.pumpClk = !s_r.pumpClk;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // A running clear takes priority over user writes to any word of its memory.
  always_ff @(posedge clk) begin
    if (s_r.segClr == CLR_RUN) begin
      segMem[s_r.segIdx] <= 8'h00;
    end else if (segWrEn && segWrIdx < 5'(`MEM_WORDS)) begin
      segMem[segWrIdx] <= segWrData;
    end
    if (s_r.blkClr == CLR_RUN) begin
      blkMem[s_r.blkIdx] <= 8'h00;
    end else if (blkWrEn && segWrIdx < 5'(`MEM_WORDS)) begin
      blkMem[segWrIdx] <= segWrData;
    end
  end
  always_comb begin
    pumpCfg.freqSel = s_r.biasCtrl[`BIAS_FSEL_LSB +: 4];
    pumpCfg.srcSel = s_r.auxCtrl[`AUX_CLKSRC_LSB +: 2];
    pumpCfg.enable = s_r.pumpOn;
  end
  pump_clock_divider u_div (
    .clk(clk),
    .nrst(nrst),
    .cfg(pumpCfg),
    .srcTicks(srcTicks),
    .pumpTick(pumpTick)
  );
  assign s_axi_awready = s_r.awHeld && s_r.wHeld && !s_r.bValid ? 1'b0 : !s_r.awHeld;
  assign s_axi_wready = !s_r.wHeld;
  assign s_axi_bresp = s_r.bResp;
  assign s_axi_bvalid = s_r.bValid;
  assign s_axi_arready = s_r.arReady;
  assign s_axi_rdata = s_r.rData;
  assign s_axi_rresp = s_r.rResp;
  assign s_axi_rvalid = s_r.rValid;
  assign shownSeg0 = s_r.shown0;
  assign displaySelect = s_r.dispSel;
  assign pumpOn = s_r.pumpOn;
  assign refCodeOut = s_r.refCode;
  assign refMillivolt = s_r.refMv;
  assign effBlinkMode = s_r.effMode;
  assign pumpClk = s_r.pumpClk;
endmodule

// >>> rtl/lcd_mem_bias_cfg.svh
// Register offsets, field positions, reset values and timing counts of the LCD memory/bias block.
`ifndef LCD_MEM_BIAS_CFG_SVH
`define LCD_MEM_BIAS_CFG_SVH
`define OFS_MEM_CTRL 4'h0
`define OFS_BIAS_CTRL 4'h4
`define OFS_AUX_CTRL 4'h8
`define OFS_STATUS 4'hC
`define MEM_DISP_BIT 0
`define MEM_CLRM_BIT 1
`define MEM_CLRBM_BIT 2
`define BIAS_PEN_BIT 7
`define BIAS_REFEN_BIT 6
`define BIAS_VREF_LSB 8
`define BIAS_FSEL_LSB 12
`define AUX_BLKMOD_LSB 0
`define AUX_MUX_LSB 2
`define AUX_EXT_BIT 5
`define AUX_CLKSRC_LSB 6
`define AUX_REFLVL_LSB 8
`define MEM_CTRL_RST 16'h0000
`define BIAS_CTRL_RST 16'h0000
`define AUX_CTRL_RST 16'h0000
`define MUX_FIVE 3'h4
`define MEM_WORDS 20
`define PUMP_POST_DIV 3'h7
`define VREF_BASE_MV 12'hA28
`define VREF_STEP_MV 12'h03C
`endif

// >>> rtl/lcd_mem_bias_pkg.sv
// Types shared by the LCD memory and bias control block.
package lcd_mem_bias_pkg;
  typedef enum logic [1:0] {
    BLINK_OFF = 2'b00,
    BLINK_SEL = 2'b01,
    BLINK_ALL = 2'b10,
    BLINK_ALT = 2'b11
  } blink_mode_e;
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_RUN = 2'b01
  } clr_state_e;
  typedef struct packed {
    logic [3:0] freqSel;
    logic [1:0] srcSel;
    logic enable;
  } pump_cfg_s;
endpackage

// >>> rtl/pump_clock_divider.sv
// Charge-pump clock divider: source enable divided by field plus one, then by eight.
`timescale 1ns/1ns
`include "lcd_mem_bias_cfg.svh"
module pump_clock_divider
  import lcd_mem_bias_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire pump_cfg_s cfg,
  input wire logic [2:0] srcTicks,
  output logic pumpTick
);
  typedef struct packed {
    logic [3:0] pre;
    logic [2:0] post;
    logic tick;
  } div_s;
  div_s s_r;
  div_s s_nxt;
  logic srcTick;
  always_comb begin
    srcTick = (cfg.srcSel == 2'h0) ? srcTicks[0] :
              (cfg.srcSel == 2'h1) ? srcTicks[1] : srcTicks[2];
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!cfg.enable) begin
      s_nxt.pre = 4'h0;
      s_nxt.post = 3'h0;
    end else if (srcTick) begin
      if (s_r.pre >= cfg.freqSel) begin
        s_nxt.pre = 4'h0;
        if (s_r.post == `PUMP_POST_DIV) begin
          s_nxt.post = 3'h0;
          s_nxt.tick = 1'b1;
        end else begin
          s_nxt.post = s_r.post + 3'h1;
        end
      end else begin
        s_nxt.pre = s_r.pre + 4'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign pumpTick = s_r.tick;
endmodule

// >>> testbench/lcd_mem_bias_ctrl_asserts.sv
// Port checker for the LCD memory and bias control block.
`timescale 1ns/1ns
module lcd_mem_bias_ctrl_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic altPhase,
  input wire logic displaySelect,
  input wire logic [1:0] effBlinkMode,
  input wire logic [3:0] refCodeOut,
  input wire logic [11:0] refMillivolt,
  input wire logic pumpOn,
  input wire logic pumpClk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_DISP_FORCED: assert property (
    effBlinkMode inside {2'h1, 2'h2} && $stable(effBlinkMode) |-> !displaySelect)
    else $error("display select not low in blink modes 01 and 10");
  AST_ALT_SHOWS: assert property (
    effBlinkMode == 2'h3 && $stable(effBlinkMode) && $stable(altPhase)
    |-> displaySelect == altPhase) else $error("display select not the shown memory");
  AST_EXIT_ALT: assert property (
    $past(effBlinkMode) == 2'h3 && effBlinkMode == 2'h0 |-> ##[0:1] !displaySelect)
    else $error("display select not cleared on leaving alternate mode");
  AST_MV_MAP: assert property (
    refCodeOut != 4'h0 && $stable(refCodeOut)
    |-> refMillivolt == 12'hA28 + 12'h03C * refCodeOut) else $error("reference level wrong");
  AST_PUMP_OFF: assert property (
    !pumpOn && !$past(pumpOn) |-> $stable(pumpClk)) else $error("pump clock runs while off");
  AST_WR_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid) else $error("read data late");
  AST_RD_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data repeated");
endmodule
bind lcd_mem_bias_ctrl lcd_mem_bias_ctrl_asserts lcd_mem_bias_ctrl_asserts_inst (.*);

// >>> testbench/test_lcd_mem_bias_ctrl.sv
// Register-level testbench of the LCD memory and bias control block.
`timescale 1ns/1ns
`include "lcd_mem_bias_cfg.svh"
module test_lcd_mem_bias_ctrl;
  import lcd_mem_bias_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, altPhase = 1'h0, segWrEn = 1'h0, blkWrEn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [2:0] srcTicks = 3'h0;
  logic [4:0] segWrIdx = 5'h0;
  logic [7:0] segWrData = 8'h0, shownSeg0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic displaySelect, pumpOn, pumpClk;
  logic [1:0] s_axi_bresp, s_axi_rresp, effBlinkMode, rsp, srcIdx = 2'h0, tk = 2'h0;
  logic [3:0] refCodeOut;
  logic [11:0] refMillivolt;
  int errors = 0, cmp_count = 0, cyc = 0;
  time t0;
  lcd_mem_bias_ctrl lcd_mem_bias_ctrl_inst (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  // Source enables pulse every fourth cycle on the selected source only.
  always @(posedge clk) begin
    tk <= tk + 2'h1;
    srcTicks <= (tk == 2'h0) ? 3'h1 << srcIdx : 3'h0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask
  task settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    for (int a = 0; a < 12; a += 4) rc(4'(a), 32'h0);
    wr(`OFS_MEM_CTRL, 16'hFFF8);
    chk(rsp, 2'h0);
    rc(`OFS_MEM_CTRL, 32'h0);
    rd(4'h2);
    chk(rsp, 2'h2);
    wr(4'h2, 16'h0);
    chk(rsp, 2'h2);
    $display("reset and map test done");
    @(posedge clk);
    segWrData <= 8'hA5;
    segWrEn <= 1'h1;
    @(posedge clk);
    segWrEn <= 1'h0;
    blkWrEn <= 1'h1;
    segWrData <= 8'h5A;
    @(posedge clk);
    blkWrEn <= 1'h0;
    settle();
    chk(shownSeg0, 8'hA5);
    wr(`OFS_MEM_CTRL, 16'h1);
    rc(`OFS_MEM_CTRL, 32'h1);
    chk(displaySelect, 1'h1);
    settle();
    chk(shownSeg0, 8'h5A);
    wr(`OFS_AUX_CTRL, 16'h10);
    wr(`OFS_MEM_CTRL, 16'h5);
    rc(`OFS_MEM_CTRL, 32'h0);
    wr(`OFS_AUX_CTRL, 16'h0);
    wr(`OFS_MEM_CTRL, 16'h5);
    rc(`OFS_MEM_CTRL, 32'h5);
    repeat (25) @(posedge clk);
    rc(`OFS_MEM_CTRL, 32'h1);
    settle();
    chk(shownSeg0, 8'h0);
    wr(`OFS_MEM_CTRL, 16'h2);
    rc(`OFS_MEM_CTRL, 32'h2);
    repeat (25) @(posedge clk);
    rc(`OFS_MEM_CTRL, 32'h0);
    settle();
    chk(shownSeg0, 8'h0);
    $display("memory clear test done");
    for (int m = 1; m < 3; m++) begin
      wr(`OFS_AUX_CTRL, 16'h0);
      wr(`OFS_MEM_CTRL, 16'h1);
      wr(`OFS_AUX_CTRL, 16'(m));
      wr(`OFS_MEM_CTRL, 16'h1);
      rc(`OFS_MEM_CTRL, 32'h0);
    end
    wr(`OFS_AUX_CTRL, 16'h3);
    altPhase <= 1'h1;
    wr(`OFS_MEM_CTRL, 16'h0);
    rc(`OFS_MEM_CTRL, 32'h1);
    altPhase <= 1'h0;
    rc(`OFS_MEM_CTRL, 32'h0);
    altPhase <= 1'h1;
    wr(`OFS_AUX_CTRL, 16'h0);
    rc(`OFS_MEM_CTRL, 32'h0);
    wr(`OFS_AUX_CTRL, 16'h11);
    settle();
    chk(effBlinkMode, BLINK_SEL);
    wr(`OFS_AUX_CTRL, 16'h15);
    settle();
    chk(effBlinkMode, BLINK_OFF);
    wr(`OFS_AUX_CTRL, 16'h17);
    settle();
    chk(effBlinkMode, BLINK_OFF);
    wr(`OFS_AUX_CTRL, 16'h16);
    settle();
    chk(effBlinkMode, BLINK_ALL);
    $display("display select test done");
    wr(`OFS_AUX_CTRL, 16'h0);
    for (int c = 0; c < 16; c++) begin
      wr(`OFS_BIAS_CTRL, {4'h0, 4'(c), 8'hC0});
      rc(`OFS_STATUS, 32'(`VREF_BASE_MV + `VREF_STEP_MV * c));
    end
    for (int s = 0; s < 3; s++) begin
      srcIdx <= 2'(s);
      wr(`OFS_AUX_CTRL, 16'(s << 6));
      wr(`OFS_BIAS_CTRL, 16'h15C0);
      @(posedge pumpClk);
      t0 = $time;
      @(posedge pumpClk);
      chk(32'(($time - t0) / 10), 32'd128);
    end
    wr(`OFS_BIAS_CTRL, 16'h1580);
    settle();
    chk(refCodeOut, 4'h0);
    wr(`OFS_BIAS_CTRL, 16'h1540);
    settle();
    chk(pumpOn, 1'h0);
    wr(`OFS_BIAS_CTRL, 16'h10C0);
    settle();
    chk(pumpOn, 1'h0);
    wr(`OFS_AUX_CTRL, 16'h100);
    settle();
    chk(pumpOn, 1'h1);
    wr(`OFS_AUX_CTRL, 16'h120);
    settle();
    chk(pumpOn, 1'h0);
    $display("bias test done");
    finish_test();
  end
endmodule
